// ===== hdl/aux_ctrl_bank.sv
// Auxiliary control word bank: memory and forced-state hold, error log pointer
// reset, output disable, and self-clearing restart bits for expansion units.
// Assumes a synchronous register port, a synchronous mode input from the scan
// engine, a power-on pulse after each power return, and one-cycle completion
// pulses from the units being restarted.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps

module aux_ctrl_bank #(
    parameter int ERR_ENTRIES = aux_ctrl_pkg::ERR_LOG_ENTRIES
) (
    input wire logic SYS_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [aux_ctrl_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [aux_ctrl_pkg::DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [1:0] MODE_IN,
    input wire logic POWER_ON_IN,
    input wire logic ERR_LOG_STORE_IN,
    input wire logic [aux_ctrl_pkg::BUS_UNITS-1:0] BUS_UNIT_DONE_IN,
    input wire logic [aux_ctrl_pkg::SPC_UNITS-1:0] SPECIAL_UNIT_DONE_IN,
    output logic [aux_ctrl_pkg::DATA_W-1:0] REG_RDATA_OUT,
    output aux_ctrl_pkg::io_clear_t IO_CLEAR_OUT,
    output logic FORCE_CLEAR_OUT,
    output logic OUTPUTS_OFF_OUT,
    output logic INHIBIT_LAMP_OUT,
    output logic [aux_ctrl_pkg::DATA_W-1:0] ERR_LOG_PTR_OUT,
    output logic [aux_ctrl_pkg::BUS_UNITS-1:0] BUS_UNIT_INIT_OUT,
    output logic [aux_ctrl_pkg::SPC_UNITS-1:0] SPECIAL_UNIT_INIT_OUT
);
    import aux_ctrl_pkg::*;

    // Word index of an address inside a block of words, or all ones if outside.
    function automatic logic [3:0] word_in_block(input logic [ADDR_W-1:0] addr,
                                                 input logic [ADDR_W-1:0] base,
                                                 input int count);
        logic [ADDR_W-1:0] diff;
        diff = addr - base;
        if (addr >= base && diff < ADDR_W'(count)) begin
            word_in_block = diff[3:0];
        end else begin
            word_in_block = 4'hF;
        end
    endfunction

    // Next value of a self-clearing restart vector: a write stores its word,
    // otherwise completion of an initializing unit clears its bit.
    function automatic logic [DATA_W-1:0] next_restart_word(input logic [DATA_W-1:0] cur,
                                                            input logic wr,
                                                            input logic [DATA_W-1:0] wdata,
                                                            input logic [DATA_W-1:0] done_clr);
        if (wr) begin
            next_restart_word = wdata;
        end else begin
            next_restart_word = cur & ~done_clr;
        end
    endfunction

    // User control state.
    logic mem_hold;
    logic force_hold;
    logic err_reset;
    logic out_off;
    logic [BUS_UNITS-1:0] bus_restart;
    logic [SPC_UNITS-1:0] spc_restart;
    logic [DATA_W-1:0] setup_word;
    logic [DATA_W-1:0] err_ptr;
    logic [BUS_UNITS-1:0] bus_init;
    logic [SPC_UNITS-1:0] spc_init;
    op_mode_t mode_prev;

    // Decoded writes and combinational next values.
    logic wr_aux;
    logic wr_bus;
    logic wr_setup;
    logic [3:0] spc_wr_idx;
    logic [3:0] spc_rd_idx;
    logic [3:0] spc_init_rd_idx;
    logic [BUS_UNITS-1:0] bus_done_clr;
    logic [SPC_UNITS-1:0] spc_done_clr;
    logic [BUS_UNITS-1:0] next_bus_restart;
    logic [SPC_UNITS-1:0] next_spc_restart;
    logic mode_changed;
    logic entering_run;
    logic prog_boundary;
    logic clear_io;
    logic clear_force;

    // Address decode of the write strobe.
    assign wr_aux = REG_WR_IN && (REG_ADDR_IN == AUX_OFS);
    assign wr_bus = REG_WR_IN && (REG_ADDR_IN == BUS_RESTART_OFS);
    assign wr_setup = REG_WR_IN && (REG_ADDR_IN == SETUP_OFS);
    assign spc_wr_idx = word_in_block(REG_ADDR_IN, SPC_RESTART_OFS, SPC_WORDS);
    assign spc_rd_idx = spc_wr_idx;
    assign spc_init_rd_idx = word_in_block(REG_ADDR_IN, SPC_INIT_OFS, SPC_WORDS);

    // completion clears only a unit still initializing.
    assign bus_done_clr = BUS_UNIT_DONE_IN & bus_init;
    assign spc_done_clr = SPECIAL_UNIT_DONE_IN & spc_init;

    // bus restart mapping, bit n for unit n.
    assign next_bus_restart = next_restart_word(bus_restart, wr_bus, REG_WDATA_IN, bus_done_clr);

    // six special words, consecutive unit numbers.
    always_comb begin
        next_spc_restart = spc_restart;
        for (int w = 0; w < SPC_WORDS; w++) begin
            next_spc_restart[w*DATA_W +: DATA_W] = next_restart_word(
                spc_restart[w*DATA_W +: DATA_W],
                REG_WR_IN && (spc_wr_idx == 4'(w)),
                REG_WDATA_IN,
                spc_done_clr[w*DATA_W +: DATA_W]);
        end
    end

    // Mode change classification from the scan engine's mode input.
    assign mode_changed = (op_mode_t'(MODE_IN) != mode_prev);
    assign entering_run = mode_changed && (op_mode_t'(MODE_IN) == MODE_RUN);
    assign prog_boundary = mode_changed &&
        ((mode_prev == MODE_PROGRAM) || (op_mode_t'(MODE_IN) == MODE_PROGRAM));

    // io_memory cleared on a program boundary unless held.
    // at power-on the hold bit only survives if setup keeps it.
    assign clear_io = (prog_boundary && !mem_hold) ||
        (POWER_ON_IN && !(setup_word[SETUP_KEEP_MEM_HOLD_BIT] && mem_hold));

    // forced bits cleared on program boundary unless held.
    // run entry always clears forced bits.
    // power-on keeps them only with setup and hold bit.
    assign clear_force = entering_run || (prog_boundary && !force_hold) ||
        (POWER_ON_IN && !(setup_word[SETUP_KEEP_FORCE_HOLD_BIT] && force_hold));

    // Previous operating mode for change detection.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            mode_prev <= MODE_PROGRAM;
        end else begin
            mode_prev <= op_mode_t'(MODE_IN);
        end
    end

    // Setup word with the options that keep the hold bits through power-on.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            setup_word <= WORD_RESET;
        end else if (wr_setup) begin
            setup_word <= REG_WDATA_IN;
        end
    end

    // Hold bits: written by software, kept over mode changes.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            mem_hold <= 1'b0;
            force_hold <= 1'b0;
        end else if (wr_aux) begin
            mem_hold <= REG_WDATA_IN[MEM_HOLD_BIT];
            force_hold <= REG_WDATA_IN[FORCE_HOLD_BIT];
        end else if (POWER_ON_IN) begin
            // memory-hold bit lost at power-on unless setup keeps it.
            if (!setup_word[SETUP_KEEP_MEM_HOLD_BIT]) begin
                mem_hold <= 1'b0;
            end
            // forced-hold bit lost at power-on unless setup keeps it.
            if (!setup_word[SETUP_KEEP_FORCE_HOLD_BIT]) begin
                force_hold <= 1'b0;
            end
        end
    end

    // Output-disable bit, kept through power interruptions.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            out_off <= 1'b0;
        end else if (wr_aux) begin
            // no power-on term, so the bit is retained.
            out_off <= REG_WDATA_IN[OUT_OFF_BIT];
        end
    end

    // Error log reset bit; a fresh write of one wins over the self clear.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            err_reset <= 1'b0;
        end else if (wr_aux) begin
            err_reset <= REG_WDATA_IN[ERR_RESET_BIT];
        end else if (err_reset || POWER_ON_IN) begin
            err_reset <= 1'b0;
        end
    end

    // Error log pointer: advances as entries are stored, zeroed by the reset bit.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            err_ptr <= ERR_PTR_CLEAR;
        end else if (err_reset) begin
            // only the pointer changes, entries stay.
            err_ptr <= ERR_PTR_CLEAR;
        end else if (ERR_LOG_STORE_IN && (err_ptr < DATA_W'(ERR_ENTRIES))) begin
            err_ptr <= err_ptr + 16'h0001;
        end
    end

    // Bus unit restart bits and initializing flags.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            bus_restart <= '0;
            bus_init <= '0;
        end else if (POWER_ON_IN) begin
            bus_restart <= '0;
            bus_init <= '0;
        end else begin
            bus_restart <= next_bus_restart;
            // flag follows a set restart bit
            bus_init <= (bus_init | bus_restart) & ~bus_done_clr;
        end
    end

    // Special unit restart bits and initializing flags.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            spc_restart <= '0;
            spc_init <= '0;
        end else if (POWER_ON_IN) begin
            // special restart bits cleared at power-up.
            spc_restart <= '0;
            spc_init <= '0;
        end else begin
            spc_restart <= next_spc_restart;
            // flag raised by restart bit, dropped on completion.
            spc_init <= (spc_init | spc_restart) & ~spc_done_clr;
        end
    end

    // Clear strobes to the io_memory areas and the forced-bit table.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            IO_CLEAR_OUT <= '0;
            FORCE_CLEAR_OUT <= 1'b0;
        end else begin
            // every io_memory area cleared or kept together.
            IO_CLEAR_OUT.core_io_area <= clear_io;
            IO_CLEAR_OUT.transition_flags <= clear_io;
            IO_CLEAR_OUT.timer_flags_present_values <= clear_io;
            IO_CLEAR_OUT.index_regs <= clear_io;
            IO_CLEAR_OUT.data_regs <= clear_io;
            FORCE_CLEAR_OUT <= clear_force;
        end
    end

    // Output disable and its indicator, taken from the stored bit.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            OUTPUTS_OFF_OUT <= 1'b0;
            INHIBIT_LAMP_OUT <= 1'b0;
        end else begin
            OUTPUTS_OFF_OUT <= out_off;
            INHIBIT_LAMP_OUT <= out_off;
        end
    end

    // Status outputs mirrored from their registers.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ERR_LOG_PTR_OUT <= ERR_PTR_CLEAR;
            BUS_UNIT_INIT_OUT <= '0;
            SPECIAL_UNIT_INIT_OUT <= '0;
        end else begin
            ERR_LOG_PTR_OUT <= err_ptr;
            BUS_UNIT_INIT_OUT <= bus_init;
            SPECIAL_UNIT_INIT_OUT <= spc_init;
        end
    end

    // Read data in the cycle after the read strobe; unmapped words read zero.
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            REG_RDATA_OUT <= WORD_RESET;
        end else if (REG_RD_IN) begin
            if (REG_ADDR_IN == AUX_OFS) begin
                REG_RDATA_OUT <= {out_off, err_reset, force_hold, mem_hold, 12'h000};
            end else if (REG_ADDR_IN == BUS_RESTART_OFS) begin
                REG_RDATA_OUT <= bus_restart;
            end else if (spc_rd_idx != 4'hF) begin
                REG_RDATA_OUT <= spc_restart[spc_rd_idx*DATA_W +: DATA_W];
            end else if (REG_ADDR_IN == ERR_PTR_OFS) begin
                REG_RDATA_OUT <= err_ptr;
            end else if (REG_ADDR_IN == BUS_INIT_OFS) begin
                REG_RDATA_OUT <= bus_init;
            end else if (spc_init_rd_idx != 4'hF) begin
                REG_RDATA_OUT <= spc_init[spc_init_rd_idx*DATA_W +: DATA_W];
            end else if (REG_ADDR_IN == SETUP_OFS) begin
                REG_RDATA_OUT <= setup_word;
            end else begin
                REG_RDATA_OUT <= WORD_RESET;
            end
        end else begin
            REG_RDATA_OUT <= WORD_RESET;
        end
    end

endmodule

// ===== hdl/aux_ctrl_pkg.sv
// Package for the auxiliary control word bank of the controller.
// Holds word offsets, bit positions, reset values, mode codes and carrier types.
// Assumes a 16-bit word register port addressed by word number.
package aux_ctrl_pkg;

    // Register port geometry.
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;

    // Unit counts.
    localparam int BUS_UNITS = 16;
    localparam int SPC_UNITS = 96;
    localparam int SPC_WORDS = 6;

    // Word offsets of the user control words.
    localparam logic [ADDR_W-1:0] AUX_OFS = 9'h1F4;
    localparam logic [ADDR_W-1:0] BUS_RESTART_OFS = 9'h1F5;
    localparam logic [ADDR_W-1:0] SPC_RESTART_OFS = 9'h1F6;

    // Word offsets of the status and setup words.
    localparam logic [ADDR_W-1:0] ERR_PTR_OFS = 9'h12C;
    localparam logic [ADDR_W-1:0] BUS_INIT_OFS = 9'h12E;
    localparam logic [ADDR_W-1:0] SPC_INIT_OFS = 9'h14A;
    localparam logic [ADDR_W-1:0] SETUP_OFS = 9'h0E0;

    // Bit positions in the auxiliary hold and output control word.
    localparam int MEM_HOLD_BIT = 12;
    localparam int FORCE_HOLD_BIT = 13;
    localparam int ERR_RESET_BIT = 14;
    localparam int OUT_OFF_BIT = 15;

    // Bit positions in the setup word.
    localparam int SETUP_KEEP_MEM_HOLD_BIT = 0;
    localparam int SETUP_KEEP_FORCE_HOLD_BIT = 1;

    // Reset values.
    localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] ERR_PTR_CLEAR = 16'h0000;
    localparam int ERR_LOG_ENTRIES = 20;

    // Operating modes of the controller.
    typedef enum logic [1:0] {
        MODE_PROGRAM = 2'b00,
        MODE_MONITOR = 2'b01,
        MODE_RUN = 2'b10
    } op_mode_t;

    // One clear strobe for each area of the io_memory.
    typedef struct packed {
        logic core_io_area;
        logic transition_flags;
        logic timer_flags_present_values;
        logic index_regs;
        logic data_regs;
    } io_clear_t;

endpackage

// ===== sim/aux_ctrl_bank_asserts.sv
// Port checker for the auxiliary control bank.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/1ps
module aux_ctrl_bank_asserts
    import aux_ctrl_pkg::*;
#(
    parameter int ERR_ENTRIES = 20
) (
    input wire logic SYS_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [1:0] MODE_IN,
    input wire logic POWER_ON_IN,
    input wire logic ERR_LOG_STORE_IN,
    input wire logic [BUS_UNITS-1:0] BUS_UNIT_DONE_IN,
    input wire logic [SPC_UNITS-1:0] SPECIAL_UNIT_DONE_IN,
    input wire logic [DATA_W-1:0] REG_RDATA_OUT,
    input wire io_clear_t IO_CLEAR_OUT,
    input wire logic FORCE_CLEAR_OUT,
    input wire logic OUTPUTS_OFF_OUT,
    input wire logic INHIBIT_LAMP_OUT,
    input wire logic [DATA_W-1:0] ERR_LOG_PTR_OUT,
    input wire logic [BUS_UNITS-1:0] BUS_UNIT_INIT_OUT,
    input wire logic [SPC_UNITS-1:0] SPECIAL_UNIT_INIT_OUT
);
    logic wr_aux;
    logic wr_bus;
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    // Decodes writes to the control word and the bus restart word.
    assign wr_aux = REG_WR_IN && REG_ADDR_IN == AUX_OFS;
    assign wr_bus = REG_WR_IN && REG_ADDR_IN == BUS_RESTART_OFS;
    a_lamp_tracks_off: assert property (INHIBIT_LAMP_OUT == OUTPUTS_OFF_OUT)
        else $error("Lamp differs from output disable.");
    a_off_from_bit: assert property (wr_aux ##1 !wr_aux |=>
        OUTPUTS_OFF_OUT == $past(REG_WDATA_IN[OUT_OFF_BIT], 2))
        else $error("Output disable does not follow the written bit.");
    a_io_clear_even: assert property (IO_CLEAR_OUT == '0 || IO_CLEAR_OUT == '1)
        else $error("Memory area clears disagree.");
    a_run_forces_clear: assert property ($changed(MODE_IN) && MODE_IN == MODE_RUN
        |=> FORCE_CLEAR_OUT)
        else $error("Entry into run did not clear forced bits.");
    a_monrun_keeps_io: assert property ($changed(MODE_IN) && MODE_IN != MODE_PROGRAM
        && $past(MODE_IN) != MODE_PROGRAM && !POWER_ON_IN |=> IO_CLEAR_OUT == '0)
        else $error("Memory cleared on a monitor and run change.");
    a_err_ptr_zero: assert property (wr_aux && REG_WDATA_IN[ERR_RESET_BIT]
        && !ERR_LOG_STORE_IN |-> ##[1:3] ERR_LOG_PTR_OUT == '0)
        else $error("Error log pointer not reset.");
    a_bus_flag_cause: assert property ((BUS_UNIT_INIT_OUT & ~$past(BUS_UNIT_INIT_OUT)) != '0
        |-> $past(wr_bus, 2) || $past(wr_bus, 3))
        else $error("Bus initializing flag rose without a restart write.");
    a_bus_done_clears: assert property (BUS_UNIT_DONE_IN[0] && BUS_UNIT_INIT_OUT[0]
        && !REG_WR_IN |-> ##[1:3] !BUS_UNIT_INIT_OUT[0])
        else $error("Bus flag stays after completion.");
    a_spc_done_clears: assert property (SPECIAL_UNIT_DONE_IN[95] && SPECIAL_UNIT_INIT_OUT[95]
        && !REG_WR_IN |-> ##[1:3] !SPECIAL_UNIT_INIT_OUT[95])
        else $error("Special flag stays after completion.");
    c_force_clear: cover property (FORCE_CLEAR_OUT);
    c_bus_init: cover property (|BUS_UNIT_INIT_OUT);
    c_outputs_off: cover property (OUTPUTS_OFF_OUT);
endmodule

bind aux_ctrl_bank aux_ctrl_bank_asserts #(.ERR_ENTRIES(ERR_ENTRIES)) i_chk (.*);

// ===== sim/unit_model.sv
// Model of the bus and special units that answer restart requests.
// Assumes flags come as one vector, bus units in the low 16 bits.
`timescale 1ns/1ps
module unit_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic slow_in,
    input wire logic [111:0] init_in,
    output logic [111:0] done_out
);
    logic [111:0] seen1;
    logic [111:0] seen2;
    logic [111:0] sent;
    // Each unit answers once per restart, two cycles after its flag, or three when slow_in is set.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seen1 <= '0;
            seen2 <= '0;
            sent <= '0;
            done_out <= '0;
        end else begin
            seen1 <= init_in;
            seen2 <= seen1 & init_in;
            done_out <= init_in & (slow_in ? seen2 : seen1) & ~sent & ~done_out;
            sent <= (sent | done_out) & init_in;
        end
    end
endmodule

// ===== sim/plc_aux_control_bits_bench.sv
// Self-checking bench for the auxiliary control bank.
// Assumes the unit model answers every restart it sees.
`timescale 1ns/1ps
module plc_aux_control_bits_bench;
    import aux_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [8:0] addr = '0;
    logic [15:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] mode = 2'h0;
    logic pwr = 1'b0;
    logic store = 1'b0;
    logic slow = 1'b0;
    logic [111:0] done;
    logic [15:0] rdata;
    logic [15:0] ptr;
    logic [15:0] binit;
    logic [95:0] sinit;
    io_clear_t ioc;
    logic fclr;
    logic off;
    logic lamp;
    int miscompares = 0;
    int n_checks = 0;
    int seed;
    logic [15:0] v;

    aux_ctrl_bank i_dut (
        .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .MODE_IN(mode), .POWER_ON_IN(pwr),
        .ERR_LOG_STORE_IN(store), .BUS_UNIT_DONE_IN(done[15:0]),
        .SPECIAL_UNIT_DONE_IN(done[111:16]), .REG_RDATA_OUT(rdata), .IO_CLEAR_OUT(ioc),
        .FORCE_CLEAR_OUT(fclr), .OUTPUTS_OFF_OUT(off), .INHIBIT_LAMP_OUT(lamp),
        .ERR_LOG_PTR_OUT(ptr), .BUS_UNIT_INIT_OUT(binit), .SPECIAL_UNIT_INIT_OUT(sinit));
    unit_model i_units (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow),
        .init_in({sinit, binit}), .done_out(done));

    // Free-running system clock.
    always #4 clk = ~clk;

    // Bits 12, 13 and 15 hold; bit 14 clears itself.
    function automatic logic [15:0] aux_exp(input logic [15:0] d);
        return d & 16'hB000;
    endfunction

    task automatic check(input logic [111:0] got, input logic [111:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task print_verdict;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [8:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask

    // Waits a bounded time for the flag vector, then compares it.
    task automatic wait_init(input logic [111:0] exp);
        for (int i = 0; i < 40 && {sinit, binit} !== exp; i++) begin
            @(posedge clk);
            #1;
        end
        check({sinit, binit}, exp);
        if (miscompares > 0) print_verdict();
    endtask

    // Applies a mode and power-on request, then counts clear pulses.
    task automatic pulse_chk(input logic [1:0] m, input logic p, input int io_e, input int f_e);
        int nio;
        int nf;
        nio = 0;
        nf = 0;
        @(posedge clk);
        mode <= m;
        pwr <= p;
        @(posedge clk);
        pwr <= 1'b0;
        // The clear pulses stand only in the cycle after the edge that takes the change.
        repeat (4) begin
            #1;
            nio += (ioc !== '0);
            nf += (fclr !== 1'b0);
            @(posedge clk);
        end
        check(nio, io_e);
        check(nf, f_e);
    endtask

    initial begin
        logic [1:0] mseq [6] = '{MODE_RUN, MODE_MONITOR, MODE_PROGRAM,
                                 MODE_MONITOR, MODE_RUN, MODE_PROGRAM};
        int io_t [6] = '{1, 0, 1, 0, 0, 0};
        int f_t [6] = '{1, 0, 1, 0, 1, 0};
        logic [111:0] w;
        seed = 32'hB00C;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(AUX_OFS, 16'h0000);
        rd_chk(9'h000, 16'h0000);
        $display("reset test done");
        for (int i = 0; i < 5; i++) begin
            v = (i == 0) ? 16'hFFFF : 16'($random(seed));
            wr_reg(AUX_OFS, v);
            rd_chk(AUX_OFS, aux_exp(v));
            check(off, v[OUT_OFF_BIT]);
            check(lamp, v[OUT_OFF_BIT]);
        end
        $display("control word test done");
        @(posedge clk);
        store <= 1'b1;
        repeat (3) @(posedge clk);
        store <= 1'b0;
        rd_chk(ERR_PTR_OFS, 16'h0003);
        wr_reg(AUX_OFS, 16'h4000);
        rd_chk(AUX_OFS, 16'h0000);
        rd_chk(ERR_PTR_OFS, 16'h0000);
        check(ptr, 16'h0000);
        $display("error log test done");
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            for (int k = 0; k < 7; k++) begin
                v = 16'($random(seed)) | (k == 6 ? 16'h8000 : 16'h0001);
                w = 112'(v) << (16 * k);
                wr_reg(BUS_RESTART_OFS + 9'(k), v);
                wait_init(w);
                wait_init('0);
                rd_chk(BUS_RESTART_OFS + 9'(k), 16'h0000);
            end
        end
        $display("restart test done");
        wr_reg(AUX_OFS, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            if (i == 3) wr_reg(AUX_OFS, 16'h3000);
            pulse_chk(mseq[i], 1'b0, io_t[i], f_t[i]);
        end
        $display("mode test done");
        wr_reg(SETUP_OFS, 16'h0003);
        rd_chk(SETUP_OFS, 16'h0003);
        wr_reg(AUX_OFS, 16'hB000);
        pulse_chk(MODE_PROGRAM, 1'b1, 0, 0);
        rd_chk(AUX_OFS, 16'hB000);
        wr_reg(SETUP_OFS, 16'h0000);
        pulse_chk(MODE_PROGRAM, 1'b1, 1, 1);
        rd_chk(AUX_OFS, 16'h8000);
        check(lamp, 1'b1);
        $display("power-on test done");
        print_verdict();
    end
endmodule
